/* logic/htw_walker.sv */
// Hardware table walker: per-strand miss service over a shared datapath
//
// Notes on behaviour
// - Any enabled buffer config enables strand walking
// - Eight strands, up to four fetches outstanding per strand
// - Nonzero context selects nonzero config set
// - Request context from context register zero
// - Page number sign-extends bit 47 upward
// - Entry address: base upper bits plus index
// - Quadword load issued; returns accepted any time
// - Valid, reserved zero, size, page, context
// - Only size codes 0,1,3,5 accepted
// - Instruction miss without execute permit traps
// - First qualifying entry in buffer order
// - No qualifying entry raises walk miss
// - Shared-context bits skip context compare
// - Shared context loads context register 0/1
// - Zero context: no compare, context zero
// - Translation off loads page unchanged
// - Real page high bits nonzero traps
// - Bounds from mask three times size
// - Page inside enabled range adds offset
// - Page outside all ranges traps invalid
// - Four ranges per strand, context independent
// - Real-address misses trap, never walked
// - Page bits below size cleared on load
module htw_walker
   import htw_pkg::*;
#(
   parameter int N_STRAND = HTW_STRANDS,
   parameter int N_TSB = HTW_TSBS,
   parameter int N_RANGE = HTW_RANGES
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Register port
   input wire logic [$clog2(N_STRAND)+HTW_IDX_W-1:0] reg_addr_i,
   input wire logic [63:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [63:0] reg_rdata_o,
   // Miss requests from the TLBs
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic [$clog2(N_STRAND)-1:0] req_strand_i,
   input wire logic req_inst_i,
   input wire logic req_real_i,
   input wire logic req_primary_i,
   input wire logic [63:0] req_va_i,
   // Level-2 cache load request
   output logic l2_req_valid_o,
   input wire logic l2_req_ready_i,
   output logic [HTW_PA_W-1:0] l2_req_addr_o,
   output logic [$clog2(N_STRAND)+$clog2(N_TSB)-1:0] l2_req_tag_o,
   // Level-2 cache return
   input wire logic l2_ret_valid_i,
   input wire logic [$clog2(N_STRAND)+$clog2(N_TSB)-1:0] l2_ret_tag_i,
   input wire logic [63:0] l2_ret_entry_tag_i,
   input wire logic [63:0] l2_ret_entry_data_i,
   // TLB write
   output logic tlb_wr_valid_o,
   output logic [$clog2(N_STRAND)-1:0] tlb_wr_strand_o,
   output logic tlb_wr_inst_o,
   output logic [63:0] tlb_wr_va_o,
   output logic [HTW_CTX_W-1:0] tlb_wr_ctx_o,
   output logic [63:0] tlb_wr_data_o,
   // Traps to the trap logic unit
   output logic [$clog2(N_STRAND)-1:0] trap_strand_o,
   output logic ifetch_walk_miss_trap_o,
   output logic load_store_walk_miss_trap_o,
   output logic unauthorized_fetch_trap_o,
   output logic inst_invalid_entry_trap_o,
   output logic data_invalid_entry_trap_o,
   output logic inst_real_miss_trap_o,
   output logic data_real_miss_trap_o,
   output logic inst_fast_miss_trap_o,
   output logic data_fast_miss_trap_o
);

   localparam int SW = $clog2(N_STRAND);
   localparam int TW = $clog2(N_TSB);

   ////////////////////////////////////////////////////////////////////////////
   // Storage

   logic [63:0] zcfg_q [N_STRAND][N_TSB];
   logic [63:0] nzcfg_q [N_STRAND][N_TSB];
   logic [63:0] range_q [N_STRAND][N_RANGE];
   logic [63:0] offs_q [N_STRAND][N_RANGE];
   logic [HTW_CTX_W-1:0] ctx_q [N_STRAND][4];
   logic [63:0] ent_tag_q [N_STRAND][N_TSB];
   logic [63:0] ent_data_q [N_STRAND][N_TSB];
   htw_state_e st_q [N_STRAND];
   htw_state_e st_d [N_STRAND];
   logic [63:0] va_q [N_STRAND];
   logic [HTW_CTX_W-1:0] rctx_q [N_STRAND];
   logic [N_STRAND-1:0] inst_q, prim_q, real_q, off_q;
   logic [N_TSB-1:0] need_q [N_STRAND];
   logic [N_TSB-1:0] sent_q [N_STRAND];
   logic [N_TSB-1:0] got_q [N_STRAND];
   logic [63:0] rdata_q;
   logic [SW-1:0] iss_ptr_q, res_ptr_q;
   logic l2_vld_q;
   logic [HTW_PA_W-1:0] l2_addr_q;
   logic [SW+TW-1:0] l2_tag_q;

   function automatic logic [SW-1:0] rr_pick(input logic [N_STRAND-1:0] m,
                                              input logic [SW-1:0] p);
      logic [SW-1:0] r;
      logic f;
      int k;
      r = p;
      f = 1'b0;
      k = 0;
      for (int i = 0; i < N_STRAND; i++) begin
         k = (int'(p) + i) % N_STRAND;
         if (!f && m[k]) begin
            r = SW'(k);
            f = 1'b1;
         end
      end
      return r;
   endfunction

   function automatic logic [TW-1:0] first_set(input logic [N_TSB-1:0] m);
      logic [TW-1:0] r;
      r = '0;
      for (int i = N_TSB - 1; i >= 0; i--) begin
         if (m[i]) begin
            r = TW'(i);
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register port

   wire [SW-1:0] a_str = reg_addr_i[HTW_IDX_W +: SW];
   wire [HTW_IDX_W-1:0] a_idx = reg_addr_i[HTW_IDX_W-1:0];
   wire [2:0] a_grp = a_idx[HTW_IDX_W-1:2];
   wire [1:0] a_el = a_idx[1:0];
   wire wr_z = reg_wr_i & (a_grp == HTW_GRP_ZCFG);
   wire wr_nz = reg_wr_i & (a_grp == HTW_GRP_NZCFG);
   wire wr_rng = reg_wr_i & (a_grp == HTW_GRP_RANGE);
   wire wr_off = reg_wr_i & (a_grp == HTW_GRP_OFFS);
   wire wr_ctx = reg_wr_i & (a_grp == HTW_GRP_CTX);
   wire [63:0] status_w = 64'({st_q[a_str] != HTW_IDLE, need_q[a_str], sent_q[a_str],
                               got_q[a_str]});
   wire [63:0] rd_w = (a_grp == HTW_GRP_ZCFG) ? zcfg_q[a_str][a_el] :
                      (a_grp == HTW_GRP_NZCFG) ? nzcfg_q[a_str][a_el] :
                      (a_grp == HTW_GRP_RANGE) ? range_q[a_str][a_el] :
                      (a_grp == HTW_GRP_OFFS) ? offs_q[a_str][a_el] :
                      (a_grp == HTW_GRP_CTX) ? 64'(ctx_q[a_str][a_el]) :
                      (a_idx == HTW_IDX_STATUS) ? status_w : 64'h0;

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         for (int s = 0; s < N_STRAND; s++) begin
            for (int t = 0; t < 4; t++) begin
               zcfg_q[s][t] <= HTW_REG_RESET;
               nzcfg_q[s][t] <= HTW_REG_RESET;
               range_q[s][t] <= HTW_REG_RESET;
               offs_q[s][t] <= HTW_REG_RESET;
               ctx_q[s][t] <= '0;
            end
         end
      end else begin
         if (wr_z) zcfg_q[a_str][a_el] <= reg_wdata_i;
         if (wr_nz) nzcfg_q[a_str][a_el] <= reg_wdata_i;
         if (wr_rng) range_q[a_str][a_el] <= reg_wdata_i;
         if (wr_off) offs_q[a_str][a_el] <= reg_wdata_i;
         if (wr_ctx) ctx_q[a_str][a_el] <= reg_wdata_i[HTW_CTX_W-1:0];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) rdata_q <= 64'h0;
      else if (reg_rd_i) rdata_q <= rd_w;
      else rdata_q <= 64'h0;
   end
   assign reg_rdata_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Per-strand walk state

   wire acc = req_valid_i & req_ready_o;
   assign req_ready_o = (st_q[req_strand_i] == HTW_IDLE);
   wire [N_STRAND-1:0] iss_cand, dec_cand;
   wire l2_load = (~l2_vld_q | l2_req_ready_i) & (|iss_cand);
   wire [SW-1:0] iss_str = rr_pick(iss_cand, iss_ptr_q);
   wire [TW-1:0] iss_tsb = first_set(need_q[iss_str] & ~sent_q[iss_str]);
   wire [SW-1:0] ret_str = l2_ret_tag_i[TW +: SW];
   wire [TW-1:0] ret_tsb = l2_ret_tag_i[TW-1:0];
   wire res_fire = |dec_cand;
   wire [SW-1:0] res_str = rr_pick(dec_cand, res_ptr_q);

   for (genvar gs = 0; gs < N_STRAND; gs++) begin : g_str
      wire acc_s = acc & (req_strand_i == SW'(gs));
      wire iss_s = l2_load & (iss_str == SW'(gs));
      wire ret_s = l2_ret_valid_i & (ret_str == SW'(gs));
      wire [N_TSB-1:0] zen, nzen;
      for (genvar gt = 0; gt < N_TSB; gt++) begin : g_en
         assign zen[gt] = zcfg_q[gs][gt][HTW_CFG_EN];
         assign nzen[gt] = nzcfg_q[gs][gt][HTW_CFG_EN];
      end
      wire [HTW_CTX_W-1:0] new_ctx = req_primary_i ? ctx_q[gs][HTW_CTX_P0] :
                                                     ctx_q[gs][HTW_CTX_S0];
      wire new_off = ~|{zen, nzen};
      // real requests not walked; config set select
      wire [N_TSB-1:0] new_need = (req_real_i | new_off) ? '0 :
                                  (new_ctx != '0) ? nzen : zen;

      always_comb begin
         st_d[gs] = st_q[gs];
         case (st_q[gs])
            HTW_IDLE: begin
               if (acc_s) st_d[gs] = (new_need == '0) ? HTW_DECIDE : HTW_FETCH;
            end
            HTW_FETCH: begin
               if (got_q[gs] == need_q[gs]) st_d[gs] = HTW_DECIDE;
            end
            HTW_DECIDE: begin
               if (res_fire && res_str == SW'(gs)) st_d[gs] = HTW_IDLE;
            end
            default: st_d[gs] = HTW_IDLE;
         endcase
      end

      always_ff @(posedge mclk_i) begin
         if (!nrst_i) begin
            st_q[gs] <= HTW_IDLE;
            need_q[gs] <= '0;
            sent_q[gs] <= '0;
            got_q[gs] <= '0;
            {inst_q[gs], prim_q[gs], real_q[gs], off_q[gs]} <= 4'h0;
            va_q[gs] <= 64'h0;
            rctx_q[gs] <= '0;
         end else begin
            st_q[gs] <= st_d[gs];
            if (acc_s) begin
               {inst_q[gs], prim_q[gs], real_q[gs]} <= {req_inst_i, req_primary_i, req_real_i};
               off_q[gs] <= new_off;
               va_q[gs] <= req_va_i;
               rctx_q[gs] <= new_ctx;
               need_q[gs] <= new_need;
               sent_q[gs] <= '0;
               got_q[gs] <= '0;
            end else begin
               // one fetch per enabled buffer in flight
               if (iss_s) sent_q[gs][iss_tsb] <= 1'b1;
               if (ret_s) got_q[gs][ret_tsb] <= 1'b1;
            end
         end
      end

      always_ff @(posedge mclk_i) begin
         if (ret_s) begin
            ent_tag_q[gs][ret_tsb] <= l2_ret_entry_tag_i;
            ent_data_q[gs][ret_tsb] <= l2_ret_entry_data_i;
         end
      end

      assign iss_cand[gs] = (st_q[gs] == HTW_FETCH) & (|(need_q[gs] & ~sent_q[gs]));
      assign dec_cand[gs] = (st_q[gs] == HTW_DECIDE);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared issue stage

   wire [63:0] i_va = va_q[iss_str];
   wire [63:0] i_va_sx = {{(63 - HTW_VA_HOLE_BIT){i_va[HTW_VA_HOLE_BIT]}},
                          i_va[HTW_VA_HOLE_BIT:0]};
   wire [63:0] i_cfg = (rctx_q[iss_str] != '0) ? nzcfg_q[iss_str][iss_tsb] :
                                                 zcfg_q[iss_str][iss_tsb];
   wire [HTW_PS_W-1:0] i_ps = i_cfg[HTW_CFG_PS_LSB +: HTW_PS_W];
   wire [HTW_NE_W-1:0] i_ne = i_cfg[HTW_CFG_NE_LSB +: HTW_NE_W];
   wire [63:0] i_vpn = i_va_sx >> (HTW_PAGE_SHIFT + HTW_SIZE_STEP * int'(i_ps));
   // index from entry count and page number
   wire [63:0] i_idx = i_vpn & ((64'h1 << (HTW_TSB_MIN_SHIFT + int'(i_ne))) - 64'h1);
   wire [63:0] i_base = 64'({i_cfg[HTW_BASE_MSB:HTW_BASE_LSB], HTW_BASE_LSB'(0)});
   wire [63:0] i_hmask = (64'h1 << (HTW_TSB_MIN_SHIFT + HTW_ENTRY_SHIFT + int'(i_ne)))
                         - 64'h1;
   wire [63:0] i_ptr = (i_base & ~i_hmask) | (i_idx << HTW_ENTRY_SHIFT);

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         l2_vld_q <= 1'b0;
         l2_addr_q <= '0;
         l2_tag_q <= '0;
         iss_ptr_q <= '0;
      end else if (l2_load) begin
         l2_vld_q <= 1'b1;
         l2_addr_q <= i_ptr[HTW_PA_W-1:0];
         l2_tag_q <= {iss_str, iss_tsb};
         iss_ptr_q <= iss_str + SW'(1);
      end else if (l2_req_ready_i) begin
         l2_vld_q <= 1'b0;
      end
   end
   assign l2_req_valid_o = l2_vld_q;
   assign l2_req_addr_o = l2_addr_q;
   assign l2_req_tag_o = l2_tag_q;

   ////////////////////////////////////////////////////////////////////////////
   // Shared decide stage

   wire [63:0] r_va = va_q[res_str];
   wire [63:0] r_va_sx = {{(63 - HTW_VA_HOLE_BIT){r_va[HTW_VA_HOLE_BIT]}},
                          r_va[HTW_VA_HOLE_BIT:0]};
   wire [HTW_CTX_W-1:0] r_ctx = rctx_q[res_str];
   wire r_nz = (r_ctx != '0);
   wire [N_TSB-1:0] qual;

   for (genvar gt = 0; gt < N_TSB; gt++) begin : g_qual
      wire [63:0] rc = r_nz ? nzcfg_q[res_str][gt] : zcfg_q[res_str][gt];
      wire [63:0] tg = ent_tag_q[res_str][gt];
      wire [63:0] dt = ent_data_q[res_str][gt];
      wire [HTW_SZ_W-1:0] sz = dt[HTW_SZ_W-1:0];
      wire sz_ok = (sz == HTW_SZ_8K) | (sz == HTW_SZ_64K) | (sz == HTW_SZ_4M) |
                   (sz == HTW_SZ_256M);
      wire [HTW_TAG_VA_MSB:0] vmask = (HTW_TAG_VA_MSB + 1)'(((64'h1 <<
         (HTW_PAGE_SHIFT + HTW_SIZE_STEP * int'(sz))) - 64'h1) >> HTW_TAG_VA_SHIFT);
      wire vpn_ok = ((tg[HTW_TAG_VA_MSB:0] ^ r_va_sx[63:HTW_TAG_VA_SHIFT]) & ~vmask) == '0;
      // shared contexts; zero context skips compare
      wire ign = ~r_nz | rc[HTW_CFG_UC0] | rc[HTW_CFG_UC1];
      wire ctx_ok = ign | (tg[HTW_TAG_CTX_LSB +: HTW_CTX_W] == r_ctx);
      assign qual[gt] = need_q[res_str][gt] & dt[HTW_TTE_V] &
                        (tg[HTW_TAG_RSVH_MSB:HTW_TAG_RSVH_LSB] == '0) &
                        (tg[HTW_TAG_RSVL_MSB:HTW_TAG_RSVL_LSB] == '0) & sz_ok &
                        (sz >= HTW_SZ_W'(rc[HTW_CFG_PS_LSB +: HTW_PS_W])) & vpn_ok & ctx_ok;
   end

   wire found = |qual;
   wire [TW-1:0] sel = first_set(qual);
   wire [63:0] s_cfg = r_nz ? nzcfg_q[res_str][sel] : zcfg_q[res_str][sel];
   wire [63:0] s_tag = ent_tag_q[res_str][sel];
   wire [63:0] s_data = ent_data_q[res_str][sel];
   wire s_prim = prim_q[res_str];
   wire s_inst = inst_q[res_str];
   wire s_r2p = s_cfg[HTW_CFG_R2P];

   // shared context substitution; zero context loads zero
   wire [HTW_CTX_W-1:0] s_ctx =
      ~r_nz ? '0 :
      s_cfg[HTW_CFG_UC0] ? (s_prim ? ctx_q[res_str][HTW_CTX_P0] : ctx_q[res_str][HTW_CTX_S0]) :
      s_cfg[HTW_CFG_UC1] ? (s_prim ? ctx_q[res_str][HTW_CTX_P1] : ctx_q[res_str][HTW_CTX_S1]) :
      s_tag[HTW_TAG_CTX_LSB +: HTW_CTX_W];

   wire [HTW_PN_W-1:0] rpn = s_data[HTW_TTE_PN_MSB:HTW_TTE_PN_LSB];
   wire [HTW_PN_W-1:0] pmask = HTW_PN_W'((64'h1 << (HTW_SIZE_STEP *
                                int'(s_data[HTW_SZ_W-1:0]))) - 64'h1);
   wire [HTW_PN_W-1:0] rpn_lo = rpn & ~pmask;
   wire [HTW_PN_W-1:0] rpn_hi = rpn | pmask;
   wire [N_RANGE-1:0] rhit;
   // four ranges per strand, no context term
   for (genvar gr = 0; gr < N_RANGE; gr++) begin : g_rng
      wire [63:0] rg = range_q[res_str][gr];
      assign rhit[gr] = rg[HTW_RNG_EN] & (rpn_lo >= rg[HTW_RNG_LO_LSB +: HTW_PN_W]) &
                        (rpn_hi <= rg[HTW_RNG_HI_LSB +: HTW_PN_W]);
   end
   wire [$clog2(N_RANGE)-1:0] rsel = first_set(rhit);
   wire [HTW_PN_W-1:0] ppn = rpn + offs_q[res_str][rsel][HTW_OFF_LSB +: HTW_PN_W];
   // untranslated when off; clear sub-page bits
   wire [HTW_PN_W-1:0] page_out = (s_r2p ? ppn : rpn) & ~pmask;
   wire [63:0] data_out = {s_data[63:HTW_TTE_PN_MSB+1], page_out,
                           s_data[HTW_TTE_PN_LSB-1:0]};

   htw_cause_e cause;
   always_comb begin
      cause = HTW_C_LOAD;
      if (real_q[res_str]) cause = HTW_C_REAL;
      else if (off_q[res_str]) cause = HTW_C_OFF;
      else if (!found) cause = HTW_C_MISS;
      else if (s_inst && !s_data[HTW_TTE_EP]) cause = HTW_C_UNAUTH;
      else if (s_r2p && s_data[HTW_TTE_RAHI_MSB:HTW_TTE_RAHI_LSB] != '0) cause = HTW_C_INVAL;
      else if (s_r2p && !(|rhit)) cause = HTW_C_INVAL;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result registers

   wire fire_ld = res_fire & (cause == HTW_C_LOAD);
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         res_ptr_q <= '0;
         tlb_wr_valid_o <= 1'b0;
         tlb_wr_strand_o <= '0;
         tlb_wr_inst_o <= 1'b0;
         tlb_wr_va_o <= 64'h0;
         tlb_wr_ctx_o <= '0;
         tlb_wr_data_o <= 64'h0;
         trap_strand_o <= '0;
      end else begin
         if (res_fire) res_ptr_q <= res_str + SW'(1);
         tlb_wr_valid_o <= fire_ld;
         if (res_fire) begin
            tlb_wr_strand_o <= res_str;
            tlb_wr_inst_o <= s_inst;
            tlb_wr_va_o <= r_va_sx;
            tlb_wr_ctx_o <= s_ctx;
            tlb_wr_data_o <= data_out;
            trap_strand_o <= res_str;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         {ifetch_walk_miss_trap_o, load_store_walk_miss_trap_o} <= 2'h0;
         unauthorized_fetch_trap_o <= 1'b0;
         {inst_invalid_entry_trap_o, data_invalid_entry_trap_o} <= 2'h0;
         {inst_real_miss_trap_o, data_real_miss_trap_o} <= 2'h0;
         {inst_fast_miss_trap_o, data_fast_miss_trap_o} <= 2'h0;
      end else begin
         ifetch_walk_miss_trap_o <= res_fire & (cause == HTW_C_MISS) & s_inst;
         load_store_walk_miss_trap_o <= res_fire & (cause == HTW_C_MISS) & ~s_inst;
         unauthorized_fetch_trap_o <= res_fire & (cause == HTW_C_UNAUTH);
         inst_invalid_entry_trap_o <= res_fire & (cause == HTW_C_INVAL) & s_inst;
         data_invalid_entry_trap_o <= res_fire & (cause == HTW_C_INVAL) & ~s_inst;
         inst_real_miss_trap_o <= res_fire & (cause == HTW_C_REAL) & s_inst;
         data_real_miss_trap_o <= res_fire & (cause == HTW_C_REAL) & ~s_inst;
         inst_fast_miss_trap_o <= res_fire & (cause == HTW_C_OFF) & s_inst;
         data_fast_miss_trap_o <= res_fire & (cause == HTW_C_OFF) & ~s_inst;
      end
   end

endmodule // htw_walker

/* logic/htw_pkg.sv */
// Constants, field layouts and types shared by the hardware table walker
package htw_pkg;

   // Structure
   localparam int HTW_STRANDS = 8;
   localparam int HTW_TSBS = 4;
   localparam int HTW_RANGES = 4;

   // Register port: address = {strand, index}
   localparam int HTW_IDX_W = 5;
   localparam logic [2:0] HTW_GRP_ZCFG = 3'h0;
   localparam logic [2:0] HTW_GRP_NZCFG = 3'h1;
   localparam logic [2:0] HTW_GRP_RANGE = 3'h2;
   localparam logic [2:0] HTW_GRP_OFFS = 3'h3;
   localparam logic [2:0] HTW_GRP_CTX = 3'h4;
   localparam logic [4:0] HTW_IDX_STATUS = 5'h14;
   localparam logic [1:0] HTW_CTX_P0 = 2'h0;
   localparam logic [1:0] HTW_CTX_P1 = 2'h1;
   localparam logic [1:0] HTW_CTX_S0 = 2'h2;
   localparam logic [1:0] HTW_CTX_S1 = 2'h3;
   localparam logic [63:0] HTW_REG_RESET = 64'h0;

   // Buffer configuration word
   localparam int HTW_CFG_EN = 63;
   localparam int HTW_CFG_UC0 = 62;
   localparam int HTW_CFG_UC1 = 61;
   localparam int HTW_CFG_R2P = 60;
   localparam int HTW_CFG_PS_LSB = 4;
   localparam int HTW_PS_W = 3;
   localparam int HTW_CFG_NE_LSB = 0;
   localparam int HTW_NE_W = 4;
   localparam int HTW_BASE_LSB = 13;
   localparam int HTW_BASE_MSB = 39;

   // Entry tag word
   localparam int HTW_TAG_RSVH_MSB = 63;
   localparam int HTW_TAG_RSVH_LSB = 61;
   localparam int HTW_TAG_CTX_LSB = 48;
   localparam int HTW_TAG_RSVL_MSB = 47;
   localparam int HTW_TAG_RSVL_LSB = 42;
   localparam int HTW_TAG_VA_MSB = 41;

   // Entry data word
   localparam int HTW_TTE_V = 63;
   localparam int HTW_TTE_RAHI_MSB = 55;
   localparam int HTW_TTE_RAHI_LSB = 40;
   localparam int HTW_TTE_PN_MSB = 39;
   localparam int HTW_TTE_PN_LSB = 13;
   localparam int HTW_TTE_EP = 7;
   localparam int HTW_SZ_W = 4;

   // Real range and physical offset words
   localparam int HTW_RNG_EN = 63;
   localparam int HTW_RNG_HI_LSB = 32;
   localparam int HTW_RNG_LO_LSB = 0;
   localparam int HTW_OFF_LSB = 13;

   // Address arithmetic
   localparam int HTW_PAGE_SHIFT = 13;
   localparam int HTW_SIZE_STEP = 3;
   localparam int HTW_TSB_MIN_SHIFT = 9;
   localparam int HTW_ENTRY_SHIFT = 4;
   localparam int HTW_VA_HOLE_BIT = 47;
   localparam int HTW_TAG_VA_SHIFT = 22;
   localparam int HTW_CTX_W = 13;
   localparam int HTW_PN_W = 27;
   localparam int HTW_PA_W = 40;

   // Supported page size codes
   localparam logic [3:0] HTW_SZ_8K = 4'h0;
   localparam logic [3:0] HTW_SZ_64K = 4'h1;
   localparam logic [3:0] HTW_SZ_4M = 4'h3;
   localparam logic [3:0] HTW_SZ_256M = 4'h5;

   typedef enum logic [1:0] {HTW_IDLE, HTW_FETCH, HTW_DECIDE} htw_state_e;
   typedef enum logic [2:0] {
      HTW_C_LOAD, HTW_C_REAL, HTW_C_OFF, HTW_C_MISS, HTW_C_UNAUTH, HTW_C_INVAL
   } htw_cause_e;

endpackage

/* dv/htw_assertions.sv */
// Port checker for the table walker
module htw_chk (
   // Watched ports
   input wire logic mclk_i, nrst_i, req_valid_i, req_ready_o, req_real_i, req_inst_i,
   input wire logic [2:0] req_strand_i,
   input wire logic l2_req_valid_o, l2_req_ready_i, tlb_wr_valid_o, tlb_wr_inst_o,
   input wire logic [39:0] l2_req_addr_o,
   input wire logic [63:0] tlb_wr_va_o, tlb_wr_data_o,
   input wire logic ifetch_walk_miss_trap_o, load_store_walk_miss_trap_o,
   input wire logic unauthorized_fetch_trap_o, inst_invalid_entry_trap_o,
   input wire logic data_invalid_entry_trap_o, inst_real_miss_trap_o, data_real_miss_trap_o,
   input wire logic inst_fast_miss_trap_o, data_fast_miss_trap_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   a_trap_onehot:
   assert property ($onehot0({ifetch_walk_miss_trap_o, load_store_walk_miss_trap_o,
      unauthorized_fetch_trap_o, inst_invalid_entry_trap_o, data_invalid_entry_trap_o,
      inst_real_miss_trap_o, data_real_miss_trap_o, inst_fast_miss_trap_o,
      data_fast_miss_trap_o})) else $error("two traps at once");
   a_l2_hold:
   assert property (l2_req_valid_o && !l2_req_ready_i |=> l2_req_valid_o
      && $stable(l2_req_addr_o)) else $error("cache request dropped");
   a_l2_align:
   assert property (l2_req_valid_o |-> l2_req_addr_o[3:0] == 4'h0) else $error("unaligned");
   a_real_trap:
   assert property (req_valid_i && req_ready_o && req_real_i && !req_inst_i
      |-> ##[2:60] data_real_miss_trap_o) else $error("real miss not trapped");
   a_va_sext:
   assert property (tlb_wr_valid_o |-> tlb_wr_va_o[63:48] == {16{tlb_wr_va_o[47]}})
      else $error("address hole bits");
   a_strand_busy:
   assert property ($past(req_valid_i && req_ready_o) && $stable(req_strand_i)
      |-> !req_ready_o) else $error("busy strand accepted");
   a_size_clear:
   assert property (tlb_wr_valid_o && tlb_wr_data_o[3:0] == 4'h1
      |-> tlb_wr_data_o[15:13] == 3'h0) else $error("low page bits kept");
   a_unauth_inst:
   assert property (unauthorized_fetch_trap_o |-> tlb_wr_inst_o) else $error("wrong side");
   cover property (tlb_wr_valid_o);
   cover property (unauthorized_fetch_trap_o);
   cover property (data_invalid_entry_trap_o);
endmodule // htw_chk

/* dv/htw_l2_model.sv */
// Level-2 cache stand-in answering entry loads after a random delay
module htw_l2_model (
   input wire logic mclk_i, req_v_i,
   input wire logic [39:0] addr_i,
   input wire logic [4:0] tag_i,
   output logic rdy_o, ret_v_o,
   output logic [4:0] ret_tag_o,
   output logic [63:0] ret_t_o, ret_d_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [63:0] ent_t = 64'h0, ent_d = 64'h0;
   logic [39:0] last_addr = 40'h0;
   int wait_n = 0;
   initial {rdy_o, ret_v_o, ret_tag_o, ret_t_o, ret_d_o} = '0;
   always @(posedge mclk_i) begin
      ret_v_o <= 1'b0;
      ret_t_o <= ~ent_t;
      ret_d_o <= ~ent_d;
      if (wait_n > 1) wait_n <= wait_n - 1;
      else if (wait_n == 1) begin
         wait_n <= 0;
         ret_v_o <= 1'b1;
         ret_t_o <= ent_t;
         ret_d_o <= ent_d;
      end else if (req_v_i && rdy_o) begin
         last_addr <= addr_i;
         ret_tag_o <= tag_i;
         wait_n <= 1 + $urandom % 5;
         rdy_o <= 1'b0;
      end else rdy_o <= 1'($urandom % 2);
   end
endmodule // htw_l2_model

/* dv/testbench.sv */
// Self-checking bench for the table walker
module testbench import htw_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, req_valid_i = 0;
   logic req_inst_i = 0, req_real_i = 0, req_primary_i = 0;
   logic [7:0] reg_addr_i = 0;
   logic [63:0] reg_wdata_i = 0, req_va_i = 0, reg_rdata_o, tlb_wr_va_o, tlb_wr_data_o;
   logic [63:0] l2_ret_entry_tag_i, l2_ret_entry_data_i;
   logic [2:0] req_strand_i = 0, tlb_wr_strand_o, trap_strand_o;
   logic [39:0] l2_req_addr_o;
   logic [4:0] l2_req_tag_o, l2_ret_tag_i;
   logic [12:0] tlb_wr_ctx_o;
   logic req_ready_o, l2_req_valid_o, l2_req_ready_i, l2_ret_valid_i, tlb_wr_valid_o;
   logic tlb_wr_inst_o, ifetch_walk_miss_trap_o, load_store_walk_miss_trap_o;
   logic unauthorized_fetch_trap_o, inst_invalid_entry_trap_o, data_invalid_entry_trap_o;
   logic inst_real_miss_trap_o, data_real_miss_trap_o, inst_fast_miss_trap_o;
   logic data_fast_miss_trap_o;
   wire [8:0] traps = {ifetch_walk_miss_trap_o, load_store_walk_miss_trap_o,
      unauthorized_fetch_trap_o, inst_invalid_entry_trap_o, data_invalid_entry_trap_o,
      inst_real_miss_trap_o, data_real_miss_trap_o, inst_fast_miss_trap_o,
      data_fast_miss_trap_o};
   int fails = 0, n_compared = 0, cyc = 0;
   htw_walker dut (.*);
   htw_l2_model l2 (.mclk_i, .req_v_i(l2_req_valid_o), .addr_i(l2_req_addr_o),
      .tag_i(l2_req_tag_o), .rdy_o(l2_req_ready_i), .ret_v_o(l2_ret_valid_i),
      .ret_tag_o(l2_ret_tag_i), .ret_t_o(l2_ret_entry_tag_i), .ret_d_o(l2_ret_entry_data_i));
   initial forever #20 mclk_i = ~mclk_i;
   ////////////////////////////////////////////////////////////////////////////
   task tally_and_finish;
      $display("compared %0d fails %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   task chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [63:0] d);
      @(posedge mclk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
      @(posedge mclk_i) reg_wr_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [63:0] d);
      @(posedge mclk_i) {reg_addr_i, reg_rd_i} <= {a, 1'b1};
      @(posedge mclk_i) reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   // One miss: case k picks the entry flaw or the walk outcome
   task go(input int k);
      logic [63:0] va, cfg, got;
      logic [2:0] s;
      logic p;
      logic [12:0] c;
      logic [26:0] rpn, off;
      int n;
      s = 3'($urandom);
      c = 13'($urandom % 8191 + 1);
      rpn = 27'($urandom);
      off = 27'($urandom);
      p = 1'($urandom);
      va = {$urandom, $urandom};
      va[63:48] = {16{va[47]}};
      cfg = 64'h0;
      cfg[63] = 1'b1;
      cfg[62] = k == 7;
      cfg[60] = k == 4 || k == 5 || k == 8;
      cfg[39:13] = 27'($urandom);
      wr({s, 5'h04}, cfg);
      wr({s, p ? 5'h10 : 5'h12}, 64'(c));
      wr({s, 5'h08}, {k == 8, 4'h0, 27'h7ffffff, 5'h0, 27'h0});
      wr({s, 5'h0c}, {24'h0, off, 13'h0});
      l2.ent_t = {3'h0, (k == 7) ? ~c : c, 6'h0, va[63:22]};
      l2.ent_d = {1'b1 ^ (k == 1), 7'h0, 15'h0, k == 4, rpn, 5'h0, k != 2, 3'h0, 4'h0};
      l2.ent_d[3:0] = (k == 3) ? 4'h2 : (k == 7) ? 4'h1 : 4'h0;
      @(posedge mclk_i) {req_valid_i, req_strand_i, req_inst_i, req_real_i} <=
         {1'b1, s, k == 2, k == 6};
      {req_primary_i, req_va_i} <= {p, 16'($urandom), va[47:0]};
      @(posedge mclk_i) req_valid_i <= 1'b0;
      #1 n = 0;
      while (!(tlb_wr_valid_o === 1'b1 || traps !== 9'h0) && n < 300) begin
         @(posedge mclk_i) #1 n++;
      end
      chk(traps, (k == 1 || k == 3) ? 9'h080 : k == 2 ? 9'h040 : k == 6 ? 9'h004 :
         (k == 4 || k == 5) ? 9'h010 : 9'h0);
      chk(tlb_wr_valid_o, k == 0 || k == 7 || k == 8);
      chk(tlb_wr_strand_o, s);
      chk(trap_strand_o, s);
      if (k != 6) chk(l2.last_addr, {cfg[39:13], 13'h0} | (va[21:13] << 4));
      if (k == 0 || k == 7 || k == 8) begin
         chk(tlb_wr_data_o[39:13], (k == 7) ? {rpn[26:3], 3'h0} :
            (k == 8) ? 27'(rpn + off) : rpn);
         chk(tlb_wr_va_o, va);
         chk(tlb_wr_ctx_o, c);
      end
      rd({s, p ? 5'h10 : 5'h12}, got);
      chk(got, 64'(c));
      rd({s, 5'h15}, got);
      chk(got, 64'h0);
      $display("test %0d done", k);
   endtask
   initial begin
      void'($urandom(32'h66d532ee));
      repeat (4) @(posedge mclk_i);
      nrst_i <= 1'b1;
      for (int i = 0; i < 27; i++) go(i % 9);
      tally_and_finish();
   end
endmodule // testbench
bind htw_walker htw_chk chk (.*);
